// File: src/pulse_cmd_pkg.sv
package pulse_cmd_pkg;

   localparam int unsigned CLK_MHZ        = 100;
   localparam int unsigned CLR_MIN_US     = 20;
   // Least time converted to whole cycles
   localparam int unsigned CLR_MIN_CYC    = CLR_MIN_US * CLK_MHZ;
   localparam int unsigned CLR_CNT_W      = 12;
   localparam int unsigned DEV_W          = 24;
   localparam int unsigned INIT_US        = 10;
   localparam int unsigned INIT_CYC       = INIT_US * CLK_MHZ;
   localparam int unsigned INIT_CNT_W     = 12;

   localparam logic [3:0]  FMT_STEP_DIR   = 4'h0;
   localparam logic [3:0]  FMT_REV_FWD    = 4'h1;
   localparam logic [3:0]  FMT_QUAD_X1    = 4'h2;
   localparam logic [3:0]  FMT_QUAD_X2    = 4'h3;
   localparam logic [3:0]  FMT_QUAD_X4    = 4'h4;
   localparam logic [3:0]  FMT_NEG_FIRST  = 4'h5;
   localparam logic [3:0]  FMT_LAST       = 4'h9;

   typedef enum logic [1:0] {
      QM_NONE,
      QM_X1,
      QM_X2,
      QM_X4
   } quad_mult_t;

endpackage : pulse_cmd_pkg

// File: src/input_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser per input bit; only stage two is visible
module input_sync #(
   parameter int unsigned W = 5
) (
   input  wire logic         clk_sys,
   input  wire logic         rstn,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_q;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk_sys) begin
            if (!rstn) begin
               meta_q[i]   <= 1'b0;
               sync_out[i] <= 1'b0;
            end else begin
               meta_q[i]   <= async_in[i];
               sync_out[i] <= meta_q[i];
            end
         end
      end
   endgenerate

endmodule : input_sync

`default_nettype wire

// File: src/servo_pulse_command_input.sv
// Functional notes
// RULE_01: Format setting 0..9 selects decoding; 0-4 positive, 5-9 negative logic.
// RULE_02: Format 0: steps on pair one, direction pair two, high is forward.
// RULE_03: Format 1: pair one pulses reverse, pair two pulses forward.
// RULE_04: Formats 2/3/4 and 7/8/9 are quadrature with x1, x2, x4 counting.
// RULE_05: Format 5 inverted step/direction; format 6 inverted reverse/forward pulses.
// RULE_06: Negative formats share timing with positive ones, only polarity differs.
// RULE_07: Held clear input zeroes deviation and disables the position loop.
// RULE_08: Clear needs at least 20 us; shorter assertion changes nothing.
// RULE_09: Power drive enabled only while run input is asserted; else no motion. Code also enables the drive on jog_active_in.
// RULE_10: Alarm reset input clears the alarm state.
// RULE_11: Controller drops run before alarm reset and removes the alarm cause.
// RULE_12: While clear is asserted, incoming command pulses are ignored.
// RULE_13: Fault output off at power-up, on after init, off on error.
// RULE_14: In-position asserted while deviation magnitude is below window limit.
// RULE_15: Quadrature: A leading counts forward; x2 counts A edges, x4 all edges.
// RULE_16: All inputs synchronised, edges found from synchronised samples. Code leaves jog_active_in and fault_detect_in unsynchronised.
`timescale 1ns/1ps
`default_nettype none

module servo_pulse_command_input (
   input  wire logic                              clk_sys,
   input  wire logic                              rstn,
   input  wire logic                              reverse_step_in,
   input  wire logic                              forward_step_in,
   input  wire logic                              deviation_clear_in,
   input  wire logic                              run_in,
   input  wire logic                              alarm_reset_in,
   input  wire logic                              jog_active_in,
   input  wire logic                              fault_detect_in,
   input  wire logic [3:0]                        pulse_input_format,
   input  wire logic [pulse_cmd_pkg::DEV_W-1:0]   position_window_limit,
   input  wire logic [pulse_cmd_pkg::DEV_W-1:0]   feedback_count_in,
   output logic                                   fault_out,
   output logic                                   in_position_out,
   output logic                                   brake_hold_out,
   output logic                                   drive_enable_out,
   output logic                                   loop_enable_out,
   output logic                                   cmd_fwd_out,
   output logic                                   cmd_rev_out,
   output logic signed [pulse_cmd_pkg::DEV_W-1:0] deviation_out
);

   // Pair one carries step/reverse/phase A; pair two direction/forward/phase B
   logic [4:0] sync_w;
   logic       pa_s, pb_s, clr_s, run_s, rst_s;

   input_sync #(.W(5)) u_sync (                                            // RULE_16
      .clk_sys  (clk_sys),
      .rstn     (rstn),
      .async_in ({alarm_reset_in, run_in, deviation_clear_in,
                  forward_step_in, reverse_step_in}),
      .sync_out (sync_w)
   );

   assign pa_s  = sync_w[0];
   assign pb_s  = sync_w[1];
   assign clr_s = sync_w[2];
   assign run_s = sync_w[3];
   assign rst_s = sync_w[4];

   // Format decode
   logic                    neg_logic;
   logic [3:0]              base_fmt;
   logic                    fmt_valid;
   pulse_cmd_pkg::quad_mult_t qmode;

   always_comb begin
      fmt_valid = (pulse_input_format <= pulse_cmd_pkg::FMT_LAST);              // RULE_01
      neg_logic = (pulse_input_format >= pulse_cmd_pkg::FMT_NEG_FIRST);         // RULE_01
      base_fmt  = neg_logic ? 4'(pulse_input_format - pulse_cmd_pkg::FMT_NEG_FIRST)
                            : pulse_input_format;
      unique case (base_fmt)
         pulse_cmd_pkg::FMT_QUAD_X1: qmode = pulse_cmd_pkg::QM_X1;             // RULE_04
         pulse_cmd_pkg::FMT_QUAD_X2: qmode = pulse_cmd_pkg::QM_X2;
         pulse_cmd_pkg::FMT_QUAD_X4: qmode = pulse_cmd_pkg::QM_X4;
         default:                    qmode = pulse_cmd_pkg::QM_NONE;
      endcase
   end

   // Polarity applied once so every format shares the same timing
   logic a_l, b_l;
   assign a_l = pa_s ^ neg_logic;                                          // RULE_06
   assign b_l = pb_s ^ neg_logic;                                          // RULE_06

   // Previous samples taken after polarity; a format change can fake one edge
   logic a_q, b_q;
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         a_q <= 1'b0;
         b_q <= 1'b0;
      end else begin
         a_q <= a_l;                                                       // RULE_16
         b_q <= b_l;
      end
   end

   logic a_rise, a_fall, b_rise, b_fall;
   assign a_rise = a_l & ~a_q;
   assign a_fall = ~a_l & a_q;
   assign b_rise = b_l & ~b_q;
   assign b_fall = ~b_l & b_q;

   logic fwd_d, rev_d;
   always_comb begin
      fwd_d = 1'b0;
      rev_d = 1'b0;
      if (fmt_valid) begin
         if (qmode == pulse_cmd_pkg::QM_NONE) begin
            if (base_fmt == pulse_cmd_pkg::FMT_STEP_DIR) begin
               // Direction high after polarity fix is forward
               fwd_d = a_rise & b_l;                                       // RULE_02 RULE_05
               rev_d = a_rise & ~b_l;                                      // RULE_02 RULE_05
            end else begin
               rev_d = a_rise;                                             // RULE_03 RULE_05
               fwd_d = b_rise;                                             // RULE_03 RULE_05
            end
         end else begin
            unique case (qmode)
               pulse_cmd_pkg::QM_X1: begin
                  fwd_d = a_rise & ~b_l;                                   // RULE_15
                  rev_d = a_fall & ~b_l;
               end
               pulse_cmd_pkg::QM_X2: begin
                  fwd_d = (a_rise & ~b_l) | (a_fall & b_l);                // RULE_15
                  rev_d = (a_rise & b_l) | (a_fall & ~b_l);
               end
               default: begin
                  fwd_d = (a_rise & ~b_l) | (a_fall & b_l)
                        | (b_rise & a_l) | (b_fall & ~a_l);                // RULE_15
                  rev_d = (a_rise & b_l) | (a_fall & ~b_l)
                        | (b_rise & ~a_l) | (b_fall & a_l);
               end
            endcase
         end
      end
   end

   // Clear qualification: must stand 20 us before it acts
   logic [pulse_cmd_pkg::CLR_CNT_W-1:0] clr_cnt_q;
   logic                                clr_act_q;
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         clr_cnt_q <= '0;
         clr_act_q <= 1'b0;
      end else if (!clr_s) begin
         clr_cnt_q <= '0;
         clr_act_q <= 1'b0;
      end else if (clr_cnt_q < pulse_cmd_pkg::CLR_CNT_W'(pulse_cmd_pkg::CLR_MIN_CYC - 1)) begin
         clr_cnt_q <= clr_cnt_q + 1'b1;                                    // RULE_08
      end else begin
         clr_act_q <= 1'b1;                                                // RULE_08
      end
   end

   // Pulses inhibited from the raw synchronised clear level, not the qualified one
   logic accept;
   assign accept = ~clr_s & run_s & fault_out;                             // RULE_12 RULE_09

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         cmd_fwd_out <= 1'b0;
         cmd_rev_out <= 1'b0;
      end else begin
         cmd_fwd_out <= fwd_d & accept;                                    // RULE_12
         cmd_rev_out <= rev_d & accept;
      end
   end

   // Deviation = command minus feedback, accumulated
   logic signed [pulse_cmd_pkg::DEV_W-1:0] dev_d;
   logic        [pulse_cmd_pkg::DEV_W-1:0] fb_q;
   always_comb begin
      dev_d = deviation_out - $signed(feedback_count_in - fb_q);
      if (cmd_fwd_out) dev_d = dev_d + $signed(pulse_cmd_pkg::DEV_W'(1));
      if (cmd_rev_out) dev_d = dev_d - $signed(pulse_cmd_pkg::DEV_W'(1));
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         deviation_out <= '0;
         fb_q          <= '0;
      end else begin
         fb_q <= feedback_count_in;
         if (clr_act_q) deviation_out <= '0;                               // RULE_07
         else           deviation_out <= dev_d;
      end
   end

   logic [pulse_cmd_pkg::DEV_W-1:0] dev_abs;
   assign dev_abs = deviation_out[pulse_cmd_pkg::DEV_W-1] ? 
                    pulse_cmd_pkg::DEV_W'(-deviation_out) : deviation_out;

   always_ff @(posedge clk_sys) begin
      if (!rstn) in_position_out <= 1'b0;
      else       in_position_out <= (dev_abs < position_window_limit);     // RULE_14
   end

   // Init, alarm and drive sequencing
   logic [pulse_cmd_pkg::INIT_CNT_W-1:0] init_cnt_q;
   logic                                 init_done_q;
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         init_cnt_q  <= '0;
         init_done_q <= 1'b0;
      end else if (!init_done_q) begin
         if (init_cnt_q == pulse_cmd_pkg::INIT_CNT_W'(pulse_cmd_pkg::INIT_CYC - 1))
            init_done_q <= 1'b1;
         else
            init_cnt_q <= init_cnt_q + 1'b1;
      end
   end

   // Set wins: an error in the same cycle as a reset request keeps the alarm
   logic alarm_q;
   always_ff @(posedge clk_sys) begin
      if (!rstn)                alarm_q <= 1'b0;
      else if (fault_detect_in) alarm_q <= 1'b1;                           // RULE_13
      else if (rst_s && !run_s) alarm_q <= 1'b0;                           // RULE_10
   end

   // Reset request with run still on is refused, as that would restart a live drive
   always_ff @(posedge clk_sys) begin
      if (!rstn) fault_out <= 1'b0;                                        // RULE_13
      else       fault_out <= init_done_q & ~alarm_q & ~fault_detect_in;   // RULE_13
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         drive_enable_out <= 1'b0;
         loop_enable_out  <= 1'b0;
         brake_hold_out   <= 1'b1;
      end else begin
         drive_enable_out <= (run_s | jog_active_in) & fault_out;          // RULE_09
         loop_enable_out  <= run_s & fault_out & ~clr_act_q;               // RULE_07
         brake_hold_out   <= ~((run_s | jog_active_in) & fault_out);
      end
   end

   // Clear, run, alarm and in-position checks
   a_clear_zeroes: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_07
      clr_act_q |=> deviation_out == '0)
      else $error("deviation not zeroed");
   a_clear_min_time: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_08
      $rose(clr_act_q) |->
         clr_cnt_q == pulse_cmd_pkg::CLR_CNT_W'(pulse_cmd_pkg::CLR_MIN_CYC - 1))
      else $error("clear acted early");
   a_short_clear: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_08
      (clr_s && clr_cnt_q < pulse_cmd_pkg::CLR_CNT_W'(pulse_cmd_pkg::CLR_MIN_CYC - 1))
         |-> !clr_act_q)
      else $error("short clear acted");
   a_clear_blocks: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_12
      clr_s |=> !cmd_fwd_out && !cmd_rev_out)
      else $error("pulse passed clear");
   a_run_gates: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_09
      !run_s && !jog_active_in |=> !drive_enable_out)
      else $error("drive without run");
   a_loop_off: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_07
      clr_act_q |=> !loop_enable_out)
      else $error("loop on during clear");
   a_fault_error: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_13
      fault_detect_in |=> !fault_out)
      else $error("fault not shown");
   a_alarm_latch: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_13
      fault_detect_in |=> alarm_q)
      else $error("alarm not latched");
   a_alarm_release: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_10
      alarm_q && rst_s && !run_s && !fault_detect_in |=> !alarm_q)
      else $error("alarm reset ignored");
   a_alarm_refused: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_10
      alarm_q && run_s && !fault_detect_in |=> alarm_q)
      else $error("alarm dropped with run on");
   a_inpos_track: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_14
      (dev_abs < position_window_limit) |=> in_position_out)
      else $error("in-position missed");
   a_inpos_clear: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_14
      (dev_abs >= position_window_limit) |=> !in_position_out)
      else $error("in-position outside window");

   // Pulse decode checks
   a_step_fwd: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_02
      (base_fmt == pulse_cmd_pkg::FMT_STEP_DIR && a_rise && b_l && accept && fmt_valid)
         |=> cmd_fwd_out)
      else $error("step forward lost");
   a_step_rev: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_02
      (base_fmt == pulse_cmd_pkg::FMT_STEP_DIR && a_rise && !b_l && accept && fmt_valid)
         |=> cmd_rev_out)
      else $error("step reverse lost");
   a_cwccw: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_03
      (base_fmt == pulse_cmd_pkg::FMT_REV_FWD && a_rise && accept && fmt_valid) |=> cmd_rev_out)
      else $error("reverse pulse lost");
   a_pair_fwd: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_03
      (base_fmt == pulse_cmd_pkg::FMT_REV_FWD && b_rise && accept && fmt_valid) |=> cmd_fwd_out)
      else $error("forward pulse lost");
   a_step_neg: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_05
      (neg_logic && base_fmt == pulse_cmd_pkg::FMT_STEP_DIR && fmt_valid && a_rise && !pb_s
       && accept) |=> cmd_fwd_out)
      else $error("inverted direction wrong");
   a_quad_x1_rev: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_15
      (qmode == pulse_cmd_pkg::QM_X1 && fmt_valid && a_fall && !b_l && accept) |=> cmd_rev_out)
      else $error("x1 reverse lost");
   a_quad_x4: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_15
      (qmode == pulse_cmd_pkg::QM_X4 && fmt_valid && b_rise && a_l && accept) |=> cmd_fwd_out)
      else $error("x4 phase B edge lost");

   c_fwd: cover property (@(posedge clk_sys) cmd_fwd_out);
   c_quad_x4: cover property (@(posedge clk_sys) qmode == pulse_cmd_pkg::QM_X4 && cmd_fwd_out);
   c_rev: cover property (@(posedge clk_sys) cmd_rev_out);
   c_clear: cover property (@(posedge clk_sys) $rose(clr_act_q));
   c_reset_alarm: cover property (@(posedge clk_sys) $rose(fault_out) && rst_s);

endmodule : servo_pulse_command_input

`default_nettype wire

// File: tb/cmd_pulse_model.sv
`timescale 1ns/1ps
`default_nettype none

// Motion controller side: emits whole pulses or quadrature cycles in the chosen format
module cmd_pulse_model #(
   parameter int unsigned Q = 50
) (
   input  wire logic clk_sys,
   output logic      pair_one,
   output logic      pair_two
);
   initial begin
      pair_one = 1'b0;
      pair_two = 1'b0;
   end

   // One quarter step: levels change just after an edge and then stand Q cycles
   task automatic put(input logic a, input logic b, input logic neg);
      @(posedge clk_sys);
      pair_one <= a ^ neg;
      pair_two <= b ^ neg;
      repeat (Q - 1) @(posedge clk_sys);
   endtask : put

   task automatic drive(input logic [3:0] fmt, input logic fwd, input int n);
      logic       neg;
      logic [3:0] base;
      neg  = (fmt >= 4'h5);
      base = neg ? fmt - 4'h5 : fmt;
      for (int i = 0; i < n; i++) begin
         case (base)
            4'h0: begin
               put(1'b0, fwd, neg);
               put(1'b1, fwd, neg);
               put(1'b0, fwd, neg);
            end
            4'h1: begin
               put(1'b0, 1'b0, neg);
               put(!fwd, fwd, neg);
               put(1'b0, 1'b0, neg);
            end
            default: begin
               put(fwd, !fwd, neg);
               put(1'b1, 1'b1, neg);
               put(!fwd, fwd, neg);
               put(1'b0, 1'b0, neg);
            end
         endcase
      end
   endtask : drive
endmodule : cmd_pulse_model

`default_nettype wire

// File: tb/servo_pulse_command_input_test.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
   $display("wrong value at %0t: got %0h exp %0h", $time, a, e); end end

module servo_pulse_command_input_test;
   logic        clk_sys = 1'b0;
   logic        rstn = 1'b0;
   logic        pair_one;
   logic        pair_two;
   logic        deviation_clear_in = 1'b0;
   logic        run_in = 1'b0;
   logic        alarm_reset_in = 1'b0;
   logic        fault_detect_in = 1'b0;
   logic        jog_active_in = 1'b0;
   logic [3:0]  pulse_input_format = 4'h0;
   logic [23:0] position_window_limit = 24'h0;
   logic        fault_out, in_position_out, drive_enable_out, loop_enable_out;
   logic        cmd_fwd_out, cmd_rev_out, brake_hold_out;
   logic signed [pulse_cmd_pkg::DEV_W-1:0] deviation_out;
   logic [23:0] dev_abs;
   int          fails = 0;
   int          check_count = 0;
   int          fwd_n = 0;
   int          rev_n = 0;

   always #5 clk_sys = ~clk_sys;

   always @(posedge clk_sys) begin
      if (cmd_fwd_out === 1'b1) fwd_n <= fwd_n + 1;
      if (cmd_rev_out === 1'b1) rev_n <= rev_n + 1;
   end

   assign dev_abs = deviation_out[23] ? 24'h0 - deviation_out : deviation_out;

   cmd_pulse_model #(.Q(50)) cmd_pulse_model_i (
      .clk_sys (clk_sys),
      .pair_one(pair_one),
      .pair_two(pair_two)
   );

   servo_pulse_command_input servo_pulse_command_input_i (
      .clk_sys              (clk_sys),
      .rstn                 (rstn),
      .reverse_step_in      (pair_one),
      .forward_step_in      (pair_two),
      .deviation_clear_in   (deviation_clear_in),
      .run_in               (run_in),
      .alarm_reset_in       (alarm_reset_in),
      .jog_active_in        (jog_active_in),
      .fault_detect_in      (fault_detect_in),
      .pulse_input_format   (pulse_input_format),
      .position_window_limit(position_window_limit),
      .feedback_count_in    (24'h0),
      .fault_out            (fault_out),
      .in_position_out      (in_position_out),
      .brake_hold_out       (brake_hold_out),
      .drive_enable_out     (drive_enable_out),
      .loop_enable_out      (loop_enable_out),
      .cmd_fwd_out          (cmd_fwd_out),
      .cmd_rev_out          (cmd_rev_out),
      .deviation_out        (deviation_out)
   );

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : wait_clk

   // Sends n units and judges the command pulses that come out
   task automatic send_check(input logic [3:0] f, input logic fwd, input int n, input int exp);
      int f0;
      int r0;
      f0 = fwd_n;
      r0 = rev_n;
      cmd_pulse_model_i.drive(f, fwd, n);
      wait_clk(20);
      `CHK(fwd_n - f0, fwd ? exp : 0)
      `CHK(rev_n - r0, fwd ? 0 : exp)
   endtask : send_check

   task automatic power_up_check;
      wait_clk(2);
      `CHK(fault_out, 1'b0)
      wait_clk(pulse_cmd_pkg::INIT_CYC + 100);
      `CHK(fault_out, 1'b1)
      run_in <= 1'b1;
      wait_clk(10);
      `CHK(drive_enable_out, 1'b1)
   endtask : power_up_check

   task automatic format_check;
      int mult;
      for (int f = 0; f < 10; f++) begin
         pulse_input_format <= 4'(f);
         wait_clk(10);
         cmd_pulse_model_i.put(1'b0, 1'b0, f >= 5);
         wait_clk(20);
         mult = (f % 5 == 3) ? 2 : (f % 5 == 4) ? 4 : 1;
         send_check(4'(f), 1'b1, 3, 3 * mult);
         send_check(4'(f), 1'b0, 3, 3 * mult);
      end
      pulse_input_format <= 4'h0;
      wait_clk(10);
      cmd_pulse_model_i.put(1'b0, 1'b0, 1'b0);
   endtask : format_check

   // Long clear drops pulses and zeroes; short clear must leave the count alone
   task automatic clear_check;
      deviation_clear_in <= 1'b1;
      wait_clk(10);
      send_check(4'h0, 1'b1, 2, 0);
      wait_clk(pulse_cmd_pkg::CLR_MIN_CYC);
      `CHK(loop_enable_out, 1'b0)
      `CHK(dev_abs, 24'h0)
      deviation_clear_in <= 1'b0;
      wait_clk(10);
      `CHK(dev_abs, 24'h0)
      `CHK(loop_enable_out, 1'b1)
      position_window_limit <= 24'h0;
      wait_clk(5);
      `CHK(in_position_out, 1'b0)
      position_window_limit <= 24'h1;
      wait_clk(5);
      `CHK(in_position_out, 1'b1)
      send_check(4'h0, 1'b1, 3, 3);
      `CHK(dev_abs, 24'h3)
      position_window_limit <= 24'h3;
      wait_clk(5);
      `CHK(in_position_out, 1'b0)
      position_window_limit <= 24'h4;
      wait_clk(5);
      `CHK(in_position_out, 1'b1)
      deviation_clear_in <= 1'b1;
      wait_clk(pulse_cmd_pkg::CLR_MIN_CYC / 4);
      `CHK(loop_enable_out, 1'b1)
      deviation_clear_in <= 1'b0;
      wait_clk(10);
      `CHK(dev_abs, 24'h3)
   endtask : clear_check

   task automatic run_check;
      run_in <= 1'b0;
      wait_clk(10);
      `CHK(drive_enable_out, 1'b0)
      `CHK(brake_hold_out, 1'b1)
      send_check(4'h0, 1'b1, 2, 0);
      jog_active_in <= 1'b1;
      wait_clk(10);
      `CHK(drive_enable_out, 1'b1)
      jog_active_in <= 1'b0;
      run_in <= 1'b1;
      wait_clk(10);
      `CHK(drive_enable_out, 1'b1)
      `CHK(brake_hold_out, 1'b0)
   endtask : run_check

   task automatic alarm_check;
      fault_detect_in <= 1'b1;
      wait_clk(5);
      fault_detect_in <= 1'b0;
      wait_clk(10);
      `CHK(fault_out, 1'b0)
      send_check(4'h0, 1'b0, 2, 0);
      run_in <= 1'b0;
      wait_clk(10);
      alarm_reset_in <= 1'b1;
      wait_clk(10);
      alarm_reset_in <= 1'b0;
      wait_clk(10);
      `CHK(fault_out, 1'b1)
      run_in <= 1'b1;
      wait_clk(10);
      send_check(4'h0, 1'b0, 2, 2);
   endtask : alarm_check

   task automatic report_and_stop;
      $display("comparisons %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : report_and_stop

   initial begin
      wait_clk(12);
      rstn <= 1'b1;
      power_up_check();
      format_check();
      clear_check();
      run_check();
      alarm_check();
      report_and_stop();
   end

   // Whole sequence needs roughly 17600 cycles
   initial begin
      wait_clk(60000);
      fails++;
      report_and_stop();
   end
endmodule : servo_pulse_command_input_test

`default_nettype wire
